// ---- rvf_assertions.sv ----
// Checker for the reset and vector fetch block
`timescale 1ns/1ns
module rvf_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ext_rst_n,
    input wire logic wdt_overflow,
    input wire rvf_pkg::rvf_core_req_t core_req,
    input wire logic [rvf_pkg::PC_W-1:0] fetch_addr,
    input wire logic in_reset,
    input wire logic irq_taken,
    input wire logic ext_irq_a,
    input wire logic stack_overflow,
    input wire logic reserved_fetch
);
    import rvf_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Pin quiet long enough that no filtered reset can land next edge
    sequence calm;
        ext_rst_n[*5] ##0 !in_reset && !irq_taken && !wdt_overflow;
    endsequence
    wdt_reset_a: assert property (wdt_overflow |=> fetch_addr == RESET_VECTOR && !irq_taken)
        else $error("watchdog reset");
    ext_pin_a: assert property (!ext_rst_n [*6] |-> fetch_addr == RESET_VECTOR) else $error("pin reset");
    vector_hold_a: assert property (in_reset |-> fetch_addr == RESET_VECTOR) else $error("vector load");
    pc_step_a: assert property (calm ##0 core_req.step && !core_req.jump && !core_req.ret && !core_req.irq_req
        |=> fetch_addr == $past(fetch_addr) + 14'h1) else $error("step");
    irq_entry_a: assert property (calm ##0 core_req.irq_req |=> irq_taken && fetch_addr == IRQ_VECTOR)
        else $error("irq entry");
    irq_cause_a: assert property (irq_taken |-> $past(core_req.irq_req)) else $error("irq cause");
    ovf_push_a: assert property (stack_overflow |-> irq_taken) else $error("overflow");
    rsvd_map_a: assert property (reserved_fetch == (fetch_addr inside {[RSVD_LOW_FIRST:RSVD_LOW_LAST]}
        || fetch_addr > USER_CODE_LAST)) else $error("reserved");
    irq_pulse_a: assert property (ext_irq_a |=> !ext_irq_a) else $error("irq pulse");
endmodule : rvf_checker
bind rvf_reset_vector rvf_checker chk_u (.sys_clk, .srst, .ext_rst_n, .wdt_overflow, .core_req, .fetch_addr,
    .in_reset, .irq_taken, .ext_irq_a, .stack_overflow, .reserved_fetch);

// ---- rvf_pin_model.sv ----
// Pin-side model: external reset source, pulled-up interrupt and wake pins
`timescale 1ns/1ns
module rvf_pin_model (
    input wire logic rst_req,
    input wire logic [1:0] irq_low,
    input wire logic [7:0] wake_low,
    input wire logic [7:0] p_out,
    input wire logic [7:0] p_oe,
    output logic ext_rst_n,
    output logic [1:0] irq_pins,
    output logic [7:0] wake_pins
);
    assign ext_rst_n = !rst_req;
    // Released lines fall back to their pull-ups
    assign irq_pins = ~irq_low;
    assign wake_pins = p_oe & p_out | ~p_oe & ~wake_low;
endmodule : rvf_pin_model

// ---- rvf_pkg.sv ----
// Package for the reset and vector fetch block: addresses, widths, carriers
package rvf_pkg;
    localparam int PC_W = 14;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int PORT_W = 8;
    localparam logic [PC_W-1:0] RESET_VECTOR = 14'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 14'h0008;
    localparam logic [PC_W-1:0] RSVD_LOW_FIRST = 14'h0004;
    localparam logic [PC_W-1:0] RSVD_LOW_LAST = 14'h0007;
    localparam logic [PC_W-1:0] USER_CODE_LAST = 14'h2ffb;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [SP_W-1:0] SP_FULL = 3'h7;
    localparam logic [PORT_W-1:0] PORT_RESET = 8'h00;

    typedef enum logic [1:0] {
        RVF_RUN = 2'b00,
        RVF_RESET = 2'b01,
        RVF_IRQ = 2'b10
    } rvf_state_t;

    // Core-side request group
    typedef struct packed {
        logic step;
        logic jump;
        logic [PC_W-1:0] target;
        logic ret;
        logic irq_req;
    } rvf_core_req_t;

    // Wake port pin drive pair
    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } rvf_port_drv_t;
endpackage : rvf_pkg

// ---- rvf_reset_vector.sv ----
// Reset and vector fetch: program counter, return stack, reset causes, pin sources
`timescale 1ns/1ns
//
// Contract
// [RULE1] Any reset restarts fetch at address 0000h
// [RULE2] Any reset restores all system registers' defaults
// [RULE3] Reset entry is one word at 0000h
// [RULE4] External reset pin is active low, filtered
// [RULE5] Input bits 0,1 trigger external interrupts a,b
// [RULE6] Wake port bits bidirectional and wake-capable
// [RULE7] Reserved ranges flagged; user code ends 2FFBh
// [RULE8] Interrupt pushes PC, fetches from 0008h
// [RULE9] Return stack holds eight saved PC values
module rvf_reset_vector (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ext_rst_n,
    input wire logic wdt_overflow,
    input wire rvf_pkg::rvf_core_req_t core_req,
    input wire logic inport_bit0,
    input wire logic inport_bit1,
    input wire logic [rvf_pkg::PORT_W-1:0] wake_port_in,
    input wire rvf_pkg::rvf_port_drv_t wake_port_drv,
    input wire logic [rvf_pkg::PORT_W-1:0] wake_enable,
    output logic [rvf_pkg::PORT_W-1:0] wake_port_out,
    output logic [rvf_pkg::PORT_W-1:0] wake_port_oe,
    output logic [rvf_pkg::PC_W-1:0] fetch_addr,
    output logic in_reset,
    output logic irq_taken,
    output logic ext_irq_a,
    output logic ext_irq_b,
    output logic wake_event,
    output logic [rvf_pkg::PORT_W-1:0] wake_port_val,
    output logic stack_overflow,
    output logic reserved_fetch
);
    import rvf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic ext_rst_n_s1_reg;
    logic ext_rst_n_s2_reg;
    logic ext_rst_n_s3_reg;
    logic [1:0] inport_s1_reg;
    logic [1:0] inport_s2_reg;
    logic [1:0] inport_s3_reg;
    logic [PORT_W-1:0] wake_s1_reg;
    logic [PORT_W-1:0] wake_s2_reg;

    // Pins idle high behind pull-ups, so srst presets these chains to that
    // level; the first samples after release then never read as unknown
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ext_rst_n_s1_reg <= '1;
            ext_rst_n_s2_reg <= '1;
            ext_rst_n_s3_reg <= '1;
            inport_s1_reg <= '1;
            inport_s2_reg <= '1;
            inport_s3_reg <= '1;
        end else begin
            ext_rst_n_s1_reg <= ext_rst_n;
            ext_rst_n_s2_reg <= ext_rst_n_s1_reg;
            ext_rst_n_s3_reg <= ext_rst_n_s2_reg;
            inport_s1_reg <= {inport_bit1, inport_bit0};
            inport_s2_reg <= inport_s1_reg;
            inport_s3_reg <= inport_s2_reg;
        end
    end

    // Wake levels feed only the level detector and the wake_port_val register, so they need no preset
    always_ff @(posedge sys_clk) begin
        wake_s1_reg <= wake_port_in;
        wake_s2_reg <= wake_s1_reg;
    end

    // Two agreeing samples stand in for the hysteretic input stage
    wire ext_rst_req = ~ext_rst_n_s2_reg & ~ext_rst_n_s3_reg; // RULE4
    wire any_reset = srst | ext_rst_req | wdt_overflow; // RULE2

    ////////////////////////////////////////////////////////////////////////////
    // External interrupt triggers: falling edge of each input bit
    wire irq_a_edge = inport_s3_reg[0] & ~inport_s2_reg[0]; // RULE5
    wire irq_b_edge = inport_s3_reg[1] & ~inport_s2_reg[1]; // RULE5

    // Wake-up on any enabled bit reading low while it is not output-enabled
    wire [PORT_W-1:0] wake_hits = ~wake_s2_reg & wake_enable & ~wake_port_drv.oe; // RULE6

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and return stack
    function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] sp, input logic up);
        sp_step = up ? SP_W'(sp + 1'b1) : SP_W'(sp - 1'b1);
    endfunction : sp_step

    // Reserved words are only flagged; the core decides whether to trap
    function automatic logic in_reserved(input logic [PC_W-1:0] a);
        in_reserved = (a >= RSVD_LOW_FIRST && a <= RSVD_LOW_LAST) || (a > USER_CODE_LAST);
    endfunction : in_reserved

    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;
    logic [SP_W-1:0] sp_reg;
    logic [SP_W-1:0] sp_next;
    // Depth counts valid entries so an empty-stack return can be refused
    logic [SP_W:0] depth_reg;
    logic [SP_W:0] depth_next;
    rvf_state_t state_reg;
    rvf_state_t state_next;
    logic irq_a_reg;
    logic irq_b_reg;
    logic wake_reg;
    logic ovf_reg;
    logic rsvd_reg;
    logic taken_reg;
    logic [PORT_W-1:0] wake_val_reg;
    logic [PORT_W-1:0] port_out_reg;
    logic [PORT_W-1:0] port_oe_reg;

    wire pc_inc = core_req.step;
    wire [PC_W-1:0] pc_plus = PC_W'(pc_reg + 1'b1);
    wire [SP_W-1:0] sp_top = sp_step(sp_reg, 1'b0);
    wire do_push = (state_reg == RVF_RUN) & core_req.irq_req;
    // A return with nothing saved is dropped rather than reading stale words
    wire do_pop = (state_reg == RVF_RUN) & ~core_req.irq_req & core_req.ret & (depth_reg != '0);
    wire stack_full = (depth_reg == (SP_W+1)'(STACK_DEPTH));

    ////////////////////////////////////////////////////////////////////////////
    // Next state and program counter selection
    always_comb begin
        state_next = state_reg;
        pc_next = pc_reg;
        sp_next = sp_reg;
        depth_next = depth_reg;
        case (state_reg)
            RVF_RESET: begin
                pc_next = RESET_VECTOR; // RULE1 RULE3
                state_next = RVF_RUN;
            end
            RVF_IRQ: begin
                // Dead cycle: the vector word is fetched before any new request
                state_next = RVF_RUN;
            end
            RVF_RUN: begin
                if (do_push) begin
                    // Return address is the next instruction word when stepping, else the current word
                    pc_next = IRQ_VECTOR; // RULE8
                    sp_next = sp_step(sp_reg, 1'b1); // RULE9
                    depth_next = stack_full ? depth_reg : (SP_W+1)'(depth_reg + 1'b1);
                    state_next = RVF_IRQ;
                end else if (do_pop) begin
                    // Pop reads the entry just below the pointer
                    pc_next = stack_mem[sp_top];
                    sp_next = sp_top;
                    depth_next = (SP_W+1)'(depth_reg - 1'b1);
                end else if (core_req.jump) begin
                    pc_next = core_req.target;
                end else if (pc_inc) begin
                    pc_next = pc_plus;
                end
            end
            default: begin
                state_next = RVF_RESET;
            end
        endcase
    end

    // Stack contents need no reset; depth tracks what is valid
    // Written on the push edge itself, at the slot the pointer names before it moves
    always_ff @(posedge sys_clk) begin
        if (do_push && !any_reset) begin
            stack_mem[sp_reg] <= pc_inc ? pc_plus : pc_reg; // RULE8
        end
    end

    // Every reset cause clears the same state in one edge
    always_ff @(posedge sys_clk) begin
        if (any_reset) begin
            state_reg <= RVF_RESET; // RULE1 RULE2
            pc_reg <= RESET_VECTOR;
            sp_reg <= SP_RESET;
            depth_reg <= '0;
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
            wake_reg <= 1'b0;
            ovf_reg <= 1'b0;
            rsvd_reg <= 1'b0;
            taken_reg <= 1'b0;
            wake_val_reg <= PORT_RESET;
            port_out_reg <= PORT_RESET;
            port_oe_reg <= PORT_RESET; // RULE6
        end else begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            depth_reg <= depth_next;
            irq_a_reg <= irq_a_edge;
            irq_b_reg <= irq_b_edge;
            wake_reg <= |wake_hits;
            // Wraps like the real stack; oldest entry is overwritten
            ovf_reg <= do_push & stack_full; // RULE9
            rsvd_reg <= in_reserved(pc_next); // RULE7
            taken_reg <= do_push;
            wake_val_reg <= wake_s2_reg;
            port_out_reg <= wake_port_drv.out;
            port_oe_reg <= wake_port_drv.oe; // RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from flip-flops; in_reset is a decode of state_reg
    assign fetch_addr = pc_reg;
    assign in_reset = (state_reg == RVF_RESET);
    assign irq_taken = taken_reg;
    assign ext_irq_a = irq_a_reg;
    assign ext_irq_b = irq_b_reg;
    assign wake_event = wake_reg;
    assign wake_port_val = wake_val_reg;
    assign wake_port_out = port_out_reg;
    assign wake_port_oe = port_oe_reg;
    assign stack_overflow = ovf_reg;
    assign reserved_fetch = rsvd_reg;
endmodule : rvf_reset_vector

// ---- testbench.sv ----
// Testbench for the reset and vector fetch block
`timescale 1ns/1ns
module testbench;
    import rvf_pkg::*;
    logic sys_clk = 0, srst = 1, wdt = 0, rq = 0, rn, ir, ea, eb, wev, so, rs, tk;
    logic [1:0] il = 0, ip;
    logic [7:0] wl = 0, wen = 0, wp, po, pe, wv;
    logic [PC_W-1:0] pc;
    rvf_core_req_t req = '0;
    rvf_port_drv_t drv = '0;
    int bad_count = 0, total_checks = 0;
    wire [3:0] ev = {ir, wev, eb, ea};
    always #10 sys_clk = ~sys_clk;
    rvf_pin_model pm_u (.rst_req(rq), .irq_low(il), .wake_low(wl), .p_out(po), .p_oe(pe), .ext_rst_n(rn),
        .irq_pins(ip), .wake_pins(wp));
    rvf_reset_vector dut_u (.sys_clk(sys_clk), .srst(srst), .ext_rst_n(rn), .wdt_overflow(wdt), .core_req(req),
        .inport_bit0(ip[0]), .inport_bit1(ip[1]), .wake_port_in(wp), .wake_port_drv(drv), .wake_enable(wen),
        .wake_port_out(po), .wake_port_oe(pe), .fetch_addr(pc), .in_reset(ir), .irq_taken(tk), .ext_irq_a(ea),
        .ext_irq_b(eb), .wake_event(wev), .wake_port_val(wv), .stack_overflow(so), .reserved_fetch(rs));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(logic [15:0] g, logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic await(int i);
        int n;
        for (n = 0; n < 12 && ev[i] !== 1'b1; n++) tick();
        if (n == 12) begin
            chk(16'h0, 16'h1);
            summarize();
        end
    endtask : await
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_irq;
        srst = 0;
        tick(2);
        chk(pc, RESET_VECTOR);
        req.step = 1;
        req.irq_req = 1;
        tick();
        req = '0;
        chk(pc, IRQ_VECTOR);
        chk(tk, 1'b1);
        tick();
        req.ret = 1;
        tick();
        req = '0;
        chk(pc, 14'h0001);
    endtask : t_irq
    // Ninth push overwrites the oldest entry, so pops return 8 down to 1
    task automatic t_stack;
        for (int k = 0; k < 9; k++) begin
            req.jump = 1;
            req.target = 14'(256 + k);
            tick();
            req.jump = 0;
            req.irq_req = 1;
            tick();
            req = '0;
            chk(so, k == 8);
            tick();
        end
        for (int k = 8; k > 0; k--) begin
            req.ret = 1;
            tick();
            chk(pc, 14'(256 + k));
        end
        req = '0;
    endtask : t_stack
    task automatic t_pins;
        wen = 8'hff;
        drv = 16'h050f;
        for (int b = 0; b < 2; b++) begin
            il[b] = 1;
            await(b);
            il[b] = 0;
            chk({eb, ea}, 2'b01 << b);
        end
        chk({po, pe}, 16'h050f);
        wl = 8'h0a;
        tick(5);
        chk(wev, 0);
        wl = 8'h80;
        await(2);
        chk(wv, 8'h75);
        wl = 0;
    endtask : t_pins
    // Reserved ranges sit just below the interrupt entry and above user code
    task automatic t_map;
        logic [13:0] base [3] = '{14'h2ffb, 14'h0007, 14'h0003};
        logic [1:0] flag [3] = '{2'b10, 2'b01, 2'b10};
        for (int i = 0; i < 3; i++) begin
            req.step = 0;
            req.jump = 1;
            req.target = base[i];
            tick();
            chk(rs, flag[i][0]);
            req.jump = 0;
            req.step = 1;
            tick();
            chk(pc, 14'(base[i] + 1));
            chk(rs, flag[i][1]);
        end
        req = '0;
    endtask : t_map
    // A push made before each reset must be gone afterwards, so the return is ignored
    task automatic t_resets;
        for (int c = 0; c < 2; c++) begin
            req.jump = 1;
            req.target = 14'h0123;
            tick();
            req.jump = 0;
            req.irq_req = 1;
            tick();
            req = '0;
            wdt = c == 0;
            rq = c == 1;
            tick(c ? 6 : 1);
            wdt = 0;
            rq = 0;
            await(3);
            chk(pc, RESET_VECTOR);
            chk({po, pe}, 16'h0);
            tick(c ? 3 : 1);
            req.ret = 1;
            tick();
            req = '0;
            chk(pc, RESET_VECTOR);
        end
    endtask : t_resets
    initial begin
        tick(10);
        t_irq();
        t_stack();
        t_pins();
        t_map();
        t_resets();
        summarize();
    end
endmodule : testbench
